// *** bench/pbs_chk_properties.sv ***
module pbs_chk (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       lock_irq_enable_out,
  input wire logic       lock_change_flag_out,
  input wire logic       pll_power_on_out,
  input wire logic       base_clock_select_out,
  input wire logic       auto_mode_out,
  input wire logic       lock_out,
  input wire logic       irq_out,
  input wire logic [7:0] vco_linear_range_out,
  input wire logic [3:0] ref_divider_out,
  input wire logic [3:0] eff_ref_divider_out,
  input wire logic       base_clock_out,
  input wire logic       switching_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  chk_refdiv_as_one: assert property (
    $stable(ref_divider_out) |-> eff_ref_divider_out == (ref_divider_out == 4'h0 ? 4'h1 : ref_divider_out))
    else $error("divider zero not one");
  chk_fields_frozen: assert property (
    $past(pll_power_on_out) |-> $stable({vco_linear_range_out, ref_divider_out}))
    else $error("field changed while on");
  chk_sel_needs_on: assert property (
    base_clock_select_out |-> pll_power_on_out && vco_linear_range_out != 8'h00)
    else $error("select without loop");
  chk_power_held: assert property (
    $past(base_clock_select_out) |-> pll_power_on_out)
    else $error("power cleared while selected");
  chk_manual_quiet: assert property (
    !auto_mode_out && !$past(auto_mode_out) |-> !(lock_change_flag_out || lock_irq_enable_out || irq_out))
    else $error("lock event in manual mode");
  chk_flag_on_toggle: assert property (
    auto_mode_out && $changed(lock_out) |-> lock_change_flag_out)
    else $error("flag not set on toggle");
  chk_switch_static: assert property (
    switching_out && $past(switching_out) |-> $stable(base_clock_out))
    else $error("base clock moved in switch");
  chk_switch_bounded: assert property (
    $rose(switching_out) |-> ##[1:150] !switching_out)
    else $error("switch too long");
  chk_single_change: assert property (
    $changed(pll_power_on_out) |-> $stable(base_clock_select_out))
    else $error("power and select changed together");
endmodule // pbs_chk

bind pbs_clock_ctrl pbs_chk chk_u (
  .clk_in(clk_in), .reset_in(reset_in), .lock_irq_enable_out(lock_irq_enable_out),
  .lock_change_flag_out(lock_change_flag_out), .pll_power_on_out(pll_power_on_out),
  .base_clock_select_out(base_clock_select_out), .auto_mode_out(auto_mode_out), .lock_out(lock_out),
  .irq_out(irq_out), .vco_linear_range_out(vco_linear_range_out), .ref_divider_out(ref_divider_out),
  .eff_ref_divider_out(eff_ref_divider_out), .base_clock_out(base_clock_out), .switching_out(switching_out)
);

// *** bench/pbs_sim_model.sv ***
module pbs_sim_model (
  input  wire logic        base_clock_in,
  output logic      [15:0] period_ns_out
);
  timeunit 1ns;
  timeprecision 1ps;
  time last_t = 0;
  // Consumer side: measures the base clock period it receives
  always @(posedge base_clock_in) begin
    period_ns_out <= 16'($time - last_t);
    last_t = $time;
  end
endmodule // pbs_sim_model

// *** bench/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, reset_in = 1, osc_clock_in = 0, vco_clock_in = 0, ctl_wr_in, ctl_rd_in, bw_wr_in;
  logic lock_irq_enable_in, pll_power_on_in, base_clock_select_in, auto_mode_in, filter_mode_bit_in;
  logic acq_window_in, lock_window_in, multiplier_high_reg_wr_in, multiplier_low_reg_wr_in;
  logic vco_linear_range_reg_wr_in, ref_divider_reg_wr_in;
  logic [1:0] prescale_in, vco_range_exponent_field_in;
  logic [3:0] multiplier_high_reg_in, ref_divider_reg_in;
  logic [7:0] multiplier_low_reg_in, vco_linear_range_reg_in;
  wire lock_irq_enable_out, lock_change_flag_out, pll_power_on_out, base_clock_select_out, auto_mode_out;
  wire filter_mode_bit_out, lock_out, irq_out, pll_enable_out, prescaled_vco_clock_out, base_clock_out;
  wire switching_out;
  wire [1:0] prescale_out, vco_range_exponent_field_out;
  wire [3:0] ref_divider_out, eff_ref_divider_out;
  wire [7:0] vco_linear_range_out;
  wire [11:0] multiplier_out, eff_multiplier_out;
  wire [17:0] center_range_khz_out;
  wire [15:0] period_ns;
  int n_errors = 0, total_checks = 0;
  always #2 clk_in = ~clk_in;
  always #12 osc_clock_in = ~osc_clock_in;
  always #8 vco_clock_in = ~vco_clock_in;
  pbs_clock_ctrl dut_u (
    .clk_in(clk_in), .reset_in(reset_in), .ctl_wr_in(ctl_wr_in), .ctl_rd_in(ctl_rd_in),
    .lock_irq_enable_in(lock_irq_enable_in), .pll_power_on_in(pll_power_on_in),
    .base_clock_select_in(base_clock_select_in), .prescale_in(prescale_in),
    .vco_range_exponent_field_in(vco_range_exponent_field_in), .bw_wr_in(bw_wr_in),
    .auto_mode_in(auto_mode_in), .filter_mode_bit_in(filter_mode_bit_in),
    .multiplier_high_reg_wr_in(multiplier_high_reg_wr_in), .multiplier_high_reg_in(multiplier_high_reg_in),
    .multiplier_low_reg_wr_in(multiplier_low_reg_wr_in), .multiplier_low_reg_in(multiplier_low_reg_in),
    .vco_linear_range_reg_wr_in(vco_linear_range_reg_wr_in), .vco_linear_range_reg_in(vco_linear_range_reg_in),
    .ref_divider_reg_wr_in(ref_divider_reg_wr_in), .ref_divider_reg_in(ref_divider_reg_in),
    .acq_window_in(acq_window_in), .lock_window_in(lock_window_in), .osc_clock_in(osc_clock_in),
    .vco_clock_in(vco_clock_in), .lock_irq_enable_out(lock_irq_enable_out),
    .lock_change_flag_out(lock_change_flag_out), .pll_power_on_out(pll_power_on_out),
    .base_clock_select_out(base_clock_select_out), .prescale_out(prescale_out),
    .vco_range_exponent_field_out(vco_range_exponent_field_out), .auto_mode_out(auto_mode_out),
    .filter_mode_bit_out(filter_mode_bit_out), .lock_out(lock_out), .irq_out(irq_out),
    .multiplier_out(multiplier_out), .vco_linear_range_out(vco_linear_range_out),
    .ref_divider_out(ref_divider_out), .eff_multiplier_out(eff_multiplier_out),
    .eff_ref_divider_out(eff_ref_divider_out), .pll_enable_out(pll_enable_out),
    .center_range_khz_out(center_range_khz_out), .prescaled_vco_clock_out(prescaled_vco_clock_out),
    .base_clock_out(base_clock_out), .switching_out(switching_out)
  );
  pbs_sim_model sim_u (.base_clock_in(base_clock_out), .period_ns_out(period_ns));
  ////////////////////////////////////////
  task automatic test_done();
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ctl(input logic ie, pw, sel, input logic [1:0] p);
    @(negedge clk_in);
    {ctl_wr_in, lock_irq_enable_in, pll_power_on_in, base_clock_select_in} = {1'h1, ie, pw, sel};
    {prescale_in, vco_range_exponent_field_in} = {p, p};
    @(negedge clk_in);
    ctl_wr_in = 0;
  endtask
  task automatic fld(input logic [3:0] k, input logic [11:0] v);
    @(negedge clk_in);
    {multiplier_high_reg_wr_in, multiplier_low_reg_wr_in, vco_linear_range_reg_wr_in, ref_divider_reg_wr_in} = k;
    {multiplier_high_reg_in, multiplier_low_reg_in} = v;
    {vco_linear_range_reg_in, ref_divider_reg_in} = {v[7:0], v[3:0]};
    @(negedge clk_in);
    {multiplier_high_reg_wr_in, multiplier_low_reg_wr_in, vco_linear_range_reg_wr_in, ref_divider_reg_wr_in} = 4'h0;
  endtask
  task automatic bw(input logic au, fm);
    @(negedge clk_in);
    {bw_wr_in, auto_mode_in, filter_mode_bit_in} = {1'h1, au, fm};
    @(negedge clk_in);
    bw_wr_in = 0;
  endtask
  task automatic settle();
    int i;
    repeat (3) @(negedge clk_in);
    for (i = 0; i < 200 && switching_out !== 1'h0; i++) @(negedge clk_in);
    if (i == 200) begin
      n_errors++;
      $display("Error switching expected 0 seen 1");
      test_done();
    end
    repeat (40) @(negedge clk_in);
  endtask
  ////////////////////////////////////////
  task automatic t_prog();
    chk("power", 1'h1, pll_power_on_out);
    chk("select", 1'h0, base_clock_select_out);
    chk("filter", 1'h0, filter_mode_bit_out);
    fld(4'h2, 12'h010);
    chk("range", 8'h40, vco_linear_range_out);
    ctl(0, 0, 0, 2'h1);
    chk("prescale", 2'h0, prescale_out);
    ctl(0, 0, 0, 2'h1);
    chk("prescale", 2'h1, prescale_out);
    chk("exponent", 2'h1, vco_range_exponent_field_out);
    fld(4'hD, 12'h000);
    @(negedge clk_in);
    chk("multiplier", 12'h000, multiplier_out);
    chk("eff mult", 12'h001, eff_multiplier_out);
    chk("eff refdiv", 4'h1, eff_ref_divider_out);
    fld(4'h2, 12'h000);
    ctl(0, 1, 0, 2'h1);
    ctl(0, 1, 1, 2'h1);
    chk("select", 1'h0, base_clock_select_out);
    chk("loop enable", 1'h0, pll_enable_out);
    chk("prescaled", 1'h0, prescaled_vco_clock_out);
    ctl(0, 0, 0, 2'h1);
    fld(4'h2, 12'h003);
  endtask
  task automatic t_sel();
    ctl(0, 0, 1, 2'h1);
    chk("center", 18'h002EE, center_range_khz_out);
    chk("select", 1'h0, base_clock_select_out);
    ctl(0, 1, 1, 2'h1);
    chk("power", 1'h1, pll_power_on_out);
    chk("select", 1'h0, base_clock_select_out);
    ctl(0, 0, 1, 2'h1);
    chk("power", 1'h0, pll_power_on_out);
    chk("select", 1'h0, base_clock_select_out);
    ctl(0, 1, 0, 2'h1);
    repeat (20) @(negedge clk_in);
    bw(0, 1);
    chk("filter", 1'h1, filter_mode_bit_out);
    repeat (20) @(negedge clk_in);
    ctl(0, 1, 1, 2'h1);
    repeat (2) @(negedge clk_in);
    chk("switching", 1'h1, switching_out);
    settle();
    chk("vco period", 18'h00040, period_ns);
    ctl(0, 0, 1, 2'h1);
    chk("power", 1'h1, pll_power_on_out);
    ctl(0, 1, 0, 2'h1);
    settle();
    chk("osc period", 18'h00030, period_ns);
  endtask
  task automatic t_lock();
    bw(1, 1);
    ctl(1, 1, 0, 2'h1);
    chk("auto", 1'h1, auto_mode_out);
    chk("irq enable", 1'h1, lock_irq_enable_out);
    chk("filter", 1'h0, filter_mode_bit_out);
    {acq_window_in, lock_window_in} = 2'h3;
    repeat (4) @(negedge clk_in);
    chk("filter", 1'h1, filter_mode_bit_out);
    chk("lock", 1'h1, lock_out);
    chk("flag", 1'h1, lock_change_flag_out);
    chk("irq", 1'h1, irq_out);
    ctl_rd_in = 1;
    @(negedge clk_in);
    ctl_rd_in = 0;
    chk("flag", 1'h0, lock_change_flag_out);
    @(negedge clk_in);
    chk("irq", 1'h0, irq_out);
    lock_window_in = 0;
    repeat (4) @(negedge clk_in);
    chk("lock", 1'h0, lock_out);
    chk("flag", 1'h1, lock_change_flag_out);
    bw(0, 0);
    bw(0, 0);
    chk("filter", 1'h0, filter_mode_bit_out);
    ctl(1, 1, 0, 2'h1);
    chk("irq enable", 1'h0, lock_irq_enable_out);
    lock_window_in = 1;
    repeat (4) @(negedge clk_in);
    chk("lock", 1'h0, lock_out);
    chk("flag", 1'h0, lock_change_flag_out);
    chk("irq", 1'h0, irq_out);
  endtask
  ////////////////////////////////////////
  initial begin
    {ctl_wr_in, ctl_rd_in, bw_wr_in, auto_mode_in, filter_mode_bit_in, acq_window_in, lock_window_in} = '0;
    {lock_irq_enable_in, pll_power_on_in, base_clock_select_in, prescale_in, vco_range_exponent_field_in} = '0;
    {multiplier_high_reg_wr_in, multiplier_low_reg_wr_in, vco_linear_range_reg_wr_in, ref_divider_reg_wr_in} = '0;
    {multiplier_high_reg_in, multiplier_low_reg_in, vco_linear_range_reg_in, ref_divider_reg_in} = '0;
    repeat (20) @(negedge clk_in);
    reset_in = 0;
    @(negedge clk_in);
    t_prog();
    t_sel();
    t_lock();
    test_done();
  end
endmodule // tb_top

// *** verilog/pbs_clock_ctrl.v ***
`include "pbs_consts.vh"

// Overview of operation
// - Hands-off mode: lock detector moves filter between acquisition and tracking itself.
// - Hands-off mode: filter mode bit read-only, follows tolerance window.
// - Hands-off mode: lock indicator read-only, set while in tolerance.
// - Hands-off mode: lock toggle raises interrupt when lock interrupt enable set.
// - Software mode: filter mode bit writable, one tracking, zero acquisition.
// - Software mode: lock indicator disabled, no interrupt.
// - VCO target is reference times two to P times N over R.
// - Prescaler divides VCO clock by two to the P, P from 0 to 3.
// - Center frequency is L times two to E times 125 kHz.
// - P, E, N, L, R writable only while loop power is off.
// - Zero for R or N behaves as one.
// - L of zero disables the loop and forces the oscillator clock.
// - Switch waits three oscillator edges and three prescaled VCO edges, or three system cycles when leaving the VCO; output held static.
// - Switched clock is halved for fifty percent duty.
// - VCO clock cannot be selected while the loop is off.
// - Loop power cannot clear while VCO clock is selected.
// - One write cannot change both loop power and clock selection.
// - Lock change flag set on toggle, cleared by control read or control write, reset clears.
// - Software mode: flag and enable read zero, enable not writable.
// - Select one routes prescaled VCO clock halved, zero oscillator halved.
module pbs_clock_ctrl (
  input  wire        clk_in,
  input  wire        reset_in,
  input  wire        ctl_wr_in,
  input  wire        ctl_rd_in,
  input  wire        lock_irq_enable_in,
  input  wire        pll_power_on_in,
  input  wire        base_clock_select_in,
  input  wire [1:0]  prescale_in,
  input  wire [1:0]  vco_range_exponent_field_in,
  input  wire        bw_wr_in,
  input  wire        auto_mode_in,
  input  wire        filter_mode_bit_in,
  input  wire        multiplier_high_reg_wr_in,
  input  wire [3:0]  multiplier_high_reg_in,
  input  wire        multiplier_low_reg_wr_in,
  input  wire [7:0]  multiplier_low_reg_in,
  input  wire        vco_linear_range_reg_wr_in,
  input  wire [7:0]  vco_linear_range_reg_in,
  input  wire        ref_divider_reg_wr_in,
  input  wire [3:0]  ref_divider_reg_in,
  input  wire        acq_window_in,
  input  wire        lock_window_in,
  input  wire        osc_clock_in,
  input  wire        vco_clock_in,
  output reg         lock_irq_enable_out,
  output reg         lock_change_flag_out,
  output reg         pll_power_on_out,
  output reg         base_clock_select_out,
  output reg  [1:0]  prescale_out,
  output reg  [1:0]  vco_range_exponent_field_out,
  output reg         auto_mode_out,
  output reg         filter_mode_bit_out,
  output reg         lock_out,
  output reg         irq_out,
  output reg  [11:0] multiplier_out,
  output reg  [7:0]  vco_linear_range_out,
  output reg  [3:0]  ref_divider_out,
  output reg  [11:0] eff_multiplier_out,
  output reg  [3:0]  eff_ref_divider_out,
  output reg         pll_enable_out,
  output reg  [17:0] center_range_khz_out,
  output reg         prescaled_vco_clock_out,
  output reg         base_clock_out,
  output reg         switching_out
);

  function [11:0] pbs_zero_as_one;
    input [11:0] v;
    begin
      pbs_zero_as_one = (v == 12'h000) ? 12'h001 : v;
    end
  endfunction

  function [1:0] pbs_edge_count;
    input [1:0] cnt;
    input       hit;
    begin
      pbs_edge_count = (hit && cnt != `PBS_SWITCH_EDGES) ? cnt + 2'h1 : cnt;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Clock switch states
  localparam [1:0] SW_RUN  = 2'h0;
  localparam [1:0] SW_HOLD = 2'h1;
  localparam [1:0] SW_DONE = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg  [1:0] acq_s_r;
  reg  [1:0] lock_s_r;
  reg  [1:0] osc_s_r;
  reg  [1:0] vco_s_r;
  reg        osc_d_r;
  reg        vco_d_r;

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      acq_s_r  <= 2'h0;
      lock_s_r <= 2'h0;
      osc_s_r  <= 2'h0;
      vco_s_r  <= 2'h0;
      osc_d_r  <= 1'b0;
      vco_d_r  <= 1'b0;
    end else begin
      acq_s_r  <= {acq_s_r[0], acq_window_in};
      lock_s_r <= {lock_s_r[0], lock_window_in};
      osc_s_r  <= {osc_s_r[0], osc_clock_in};
      vco_s_r  <= {vco_s_r[0], vco_clock_in};
      osc_d_r  <= osc_s_r[1];
      vco_d_r  <= vco_s_r[1];
    end
  end

  // Clocks are sampled as levels and need two system cycles in each phase
  wire osc_edge = osc_s_r[1] & ~osc_d_r;
  wire vco_edge = vco_s_r[1] & ~vco_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control and programming registers
  wire range_zero = (vco_linear_range_out == 8'h00);
  wire prog_open  = ~pll_power_on_out;
  wire on_nxt     = base_clock_select_out ? 1'b1 : pll_power_on_in;
  // A write that flips loop power leaves the selection alone
  wire on_change  = (on_nxt != pll_power_on_out);
  wire sel_req    = pll_power_on_out & ~range_zero & base_clock_select_in;
  wire sel_nxt    = on_change ? base_clock_select_out : sel_req;
  wire lock_nxt   = auto_mode_out & pll_enable_out & lock_s_r[1];
  wire lock_toggle = auto_mode_out & (lock_nxt != lock_out);

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      lock_irq_enable_out          <= 1'b0;
      lock_change_flag_out         <= 1'b0;
      pll_power_on_out             <= 1'b1;
      base_clock_select_out        <= 1'b0;
      prescale_out                 <= `PBS_RST_PRESCALE;
      vco_range_exponent_field_out <= `PBS_RST_EXPONENT;
      auto_mode_out                <= 1'b0;
      filter_mode_bit_out          <= 1'b0;
      lock_out                     <= 1'b0;
      irq_out                      <= 1'b0;
      multiplier_out               <= `PBS_RST_MULT;
      vco_linear_range_out         <= `PBS_RST_RANGE;
      ref_divider_out              <= `PBS_RST_REFDIV;
    end else begin
      if (ctl_wr_in) begin
        pll_power_on_out      <= on_nxt;
        base_clock_select_out <= sel_nxt;
        if (auto_mode_out) begin
          lock_irq_enable_out <= lock_irq_enable_in;
        end
        if (prog_open) begin
          prescale_out                 <= prescale_in;
          vco_range_exponent_field_out <= vco_range_exponent_field_in;
        end
      end else if (range_zero) begin
        base_clock_select_out <= 1'b0;
      end
      if (!auto_mode_out) begin
        lock_irq_enable_out <= 1'b0;
      end
      if (bw_wr_in) begin
        auto_mode_out <= auto_mode_in;
      end
      if (auto_mode_out) begin
        filter_mode_bit_out <= acq_s_r[1];
      end else if (bw_wr_in) begin
        filter_mode_bit_out <= filter_mode_bit_in;
      end
      lock_out <= lock_nxt;
      // A lock toggle wins over a read clear in the same cycle
      if (lock_toggle) begin
        lock_change_flag_out <= 1'b1;
      end else if (ctl_rd_in || ctl_wr_in || !auto_mode_out) begin
        lock_change_flag_out <= 1'b0;
      end
      irq_out <= auto_mode_out & lock_irq_enable_out & (lock_change_flag_out | lock_toggle);
      if (prog_open && multiplier_high_reg_wr_in) begin
        multiplier_out[11:8] <= multiplier_high_reg_in;
      end
      if (prog_open && multiplier_low_reg_wr_in) begin
        multiplier_out[7:0] <= multiplier_low_reg_in;
      end
      if (prog_open && vco_linear_range_reg_wr_in) begin
        vco_linear_range_out <= vco_linear_range_reg_in;
      end
      if (prog_open && ref_divider_reg_wr_in) begin
        ref_divider_out <= ref_divider_reg_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived frequency settings
  wire [11:0] ref_eff = pbs_zero_as_one({8'h00, ref_divider_out});
  wire [17:0] range_scaled = {10'h000, vco_linear_range_out} << vco_range_exponent_field_out;
  // Upper product bits stay zero for every L and E
  wire [33:0] center_full  = range_scaled * `PBS_NOM_FREQ_KHZ;

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      eff_multiplier_out   <= 12'h001;
      eff_ref_divider_out  <= 4'h1;
      pll_enable_out       <= 1'b0;
      center_range_khz_out <= 18'h00000;
    end else begin
      eff_multiplier_out   <= pbs_zero_as_one(multiplier_out);
      eff_ref_divider_out  <= ref_eff[3:0];
      pll_enable_out       <= pll_power_on_out & ~range_zero;
      center_range_khz_out <= center_full[17:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler on VCO edges
  reg  [2:0] pre_cnt_r;
  wire [2:0] pre_top  = (3'h1 << prescale_out) - 3'h1;
  wire       pre_wrap = vco_edge & (pre_cnt_r == pre_top);

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pre_cnt_r               <= 3'h0;
      prescaled_vco_clock_out <= 1'b0;
    end else if (!pll_enable_out) begin
      pre_cnt_r               <= 3'h0;
      prescaled_vco_clock_out <= 1'b0;
    end else if (pre_top == 3'h0) begin
      // Divide by one passes the synced VCO level straight through
      pre_cnt_r               <= 3'h0;
      prescaled_vco_clock_out <= vco_s_r[1];
    end else if (vco_edge) begin
      pre_cnt_r <= pre_wrap ? 3'h0 : pre_cnt_r + 3'h1;
      if (pre_wrap) begin
        prescaled_vco_clock_out <= 1'b1;
      end else if (pre_cnt_r == (pre_top >> 1)) begin
        prescaled_vco_clock_out <= 1'b0;
      end
    end
  end

  wire pclk_edge = pre_wrap & pll_enable_out;

  ////////////////////////////////////////////////////////////////////////////
  // Glitch-free base clock selector
  reg  [1:0] sw_state_r;
  reg        src_r;
  reg  [1:0] osc_cnt_r;
  reg  [1:0] pclk_cnt_r;
  wire       want_sel = base_clock_select_out & pll_enable_out;
  wire       src_edge = src_r ? pclk_edge : osc_edge;

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sw_state_r     <= SW_RUN;
      src_r          <= 1'b0;
      osc_cnt_r      <= 2'h0;
      pclk_cnt_r     <= 2'h0;
      base_clock_out <= 1'b0;
      switching_out  <= 1'b0;
    end else begin
      case (sw_state_r)
        SW_RUN: begin
          if (want_sel != src_r) begin
            sw_state_r    <= SW_HOLD;
            osc_cnt_r     <= 2'h0;
            pclk_cnt_r    <= 2'h0;
            switching_out <= 1'b1;
          end else if (src_edge) begin
            base_clock_out <= ~base_clock_out;
          end
        end
        SW_HOLD: begin
          osc_cnt_r  <= pbs_edge_count(osc_cnt_r, osc_edge);
          // Leaving the VCO counts system cycles, so a stopped VCO cannot hang the switch
          pclk_cnt_r <= pbs_edge_count(pclk_cnt_r, pclk_edge | ~want_sel);
          if (osc_cnt_r == `PBS_SWITCH_EDGES && pclk_cnt_r == `PBS_SWITCH_EDGES) begin
            sw_state_r <= SW_DONE;
          end
        end
        SW_DONE: begin
          src_r         <= want_sel;
          sw_state_r    <= SW_RUN;
          switching_out <= 1'b0;
        end
        default: begin
          sw_state_r <= SW_RUN;
        end
      endcase
    end
  end

endmodule // pbs_clock_ctrl

// *** verilog/pbs_consts.vh ***
`ifndef PBS_CONSTS_VH
`define PBS_CONSTS_VH
// Reset values of the programming fields
`define PBS_RST_MULT       12'h040
`define PBS_RST_RANGE      8'h40
`define PBS_RST_REFDIV     4'h1
`define PBS_RST_PRESCALE   2'h0
`define PBS_RST_EXPONENT   2'h0
// Nominal center frequency in kHz
`define PBS_NOM_FREQ_KHZ   16'h007D
// Source edges waited on each side of a switch
`define PBS_SWITCH_EDGES   2'h3
`endif
